//--- hdl/uifl_pkg.sv
package uifl_pkg;

    // register map, byte offsets on the local port
    localparam int          AW      = 3;
    localparam logic [2:0]  A_DATA  = 3'h0;
    localparam logic [2:0]  A_IER   = 3'h1;
    localparam logic [2:0]  A_ISR   = 3'h2;
    localparam logic [2:0]  A_LCR   = 3'h3;
    localparam logic [2:0]  A_EFR   = 3'h4;
    localparam logic [2:0]  A_LSR   = 3'h5;
    localparam logic [2:0]  A_MSR   = 3'h6;

    // reset values
    localparam logic [7:0]  IER_RST = 8'h00;
    localparam logic [7:0]  LCR_RST = 8'h00;
    localparam logic [7:0]  EFR_RST = 8'h00;
    localparam logic [1:0]  TRG_RST = 2'h0;
    localparam logic [7:0]  RD_ZERO = 8'h00;

    // interrupt mask fields
    localparam int IER_RX    = 0;
    localparam int IER_TX    = 1;
    localparam int IER_RLS   = 2;
    localparam int IER_MS    = 3;
    localparam int IER_SLEEP = 4;
    localparam int IER_XOFF  = 5;
    localparam int IER_RTS   = 6;
    localparam int IER_CTS   = 7;

    // fifo setup fields
    localparam int FCR_EN    = 0;
    localparam int FCR_RXRST = 1;
    localparam int FCR_TXRST = 2;
    localparam int FCR_TXT   = 4;
    localparam int FCR_RXT   = 6;

    // character format fields
    localparam int LCR_WL    = 0;
    localparam int LCR_STB   = 2;
    localparam int LCR_PEN   = 3;
    localparam int LCR_EPS   = 4;
    localparam int LCR_STK   = 5;
    localparam int LCR_BRK   = 6;
    localparam int LCR_DLAB  = 7;

    // enhanced feature fields
    localparam int EFR_ENH   = 4;
    localparam int EFR_ARTS  = 6;
    localparam int EFR_ACTS  = 7;

    // status codes, bits 5..0
    localparam logic [5:0] C_LS    = 6'h06;
    localparam logic [5:0] C_RXTO  = 6'h0c;
    localparam logic [5:0] C_RECEIVE_DATA_READY_IRQ = 6'h04;
    localparam logic [5:0] C_TRANSMIT_READY_IRQ = 6'h02;
    localparam logic [5:0] C_MS    = 6'h00;
    localparam logic [5:0] C_XS    = 6'h10;
    localparam logic [5:0] C_FLOW  = 6'h20;
    localparam logic [5:0] C_NONE  = 6'h01;

    // trigger levels for codes 00..11
    localparam logic [4:0] TRIG_L0 = 5'h01;
    localparam logic [4:0] TRIG_L1 = 5'h04;
    localparam logic [4:0] TRIG_L2 = 5'h08;
    localparam logic [4:0] TRIG_L3 = 5'h0e;

    // character timing, in bit times; TO_CHARS counts characters
    localparam logic [3:0] WL_BASE       = 4'h5;
    localparam logic [3:0] START_BITS    = 4'h1;
    localparam logic [3:0] STOP_ONE      = 4'h1;
    localparam logic [3:0] STOP_LONG     = 4'h2;
    localparam logic [5:0] TO_CHARS      = 6'h04;
    localparam logic [5:0] TO_EXTRA_BITS = 6'h0c;

    // sticky flag indices
    localparam int F_LS   = 0;
    localparam int F_TO   = 1;
    localparam int F_TX   = 2;
    localparam int F_MS   = 3;
    localparam int F_XOFF = 4;
    localparam int F_SPEC = 5;
    localparam int F_CTS  = 6;
    localparam int F_RTS  = 7;
    localparam int F_WAKE = 8;
    localparam int NFLAG  = 9;

    typedef enum logic [3:0] {
        SRC_NONE  = 4'b0000,
        SRC_LS    = 4'b0001,
        SRC_RXTO  = 4'b0010,
        SRC_RECEIVE_DATA_READY_IRQ = 4'b0011,
        SRC_TRANSMIT_READY_IRQ = 4'b0100,
        SRC_MS    = 4'b0101,
        SRC_XS    = 4'b0110,
        SRC_FLOW  = 4'b0111,
        SRC_WAKE  = 4'b1000
    } uifl_src_e;

endpackage

//--- hdl/uifl_trig_sel.sv
`timescale 1ns/1ps
module uifl_trig_sel (
    // selection
    input  wire logic [1:0] code,
    // decoded level
    output logic      [4:0] level
);
    import uifl_pkg::*;

    assign level = (code == 2'h0) ? TRIG_L0 :
                   (code == 2'h1) ? TRIG_L1 :
                   (code == 2'h2) ? TRIG_L2 : TRIG_L3;

endmodule // uifl_trig_sel

//--- hdl/uifl_rx_timeout.sv
`timescale 1ns/1ps
module uifl_rx_timeout (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    // timing
    input  wire logic       bit_tick,
    input  wire logic       restart,
    input  wire logic       armed,
    input  wire logic [5:0] limit,
    // result
    output logic            fire
);
    import uifl_pkg::*;

    logic [5:0] cnt_r;
    logic       done_r;
    logic       fire_r;

    wire        idle     = restart | ~armed;
    wire  [5:0] cnt_inc  = cnt_r + 6'h01;
    // fires once per idle spell; a new character or a read rearms it
    wire        hit      = bit_tick & ~idle & ~done_r & (cnt_inc == limit);
    wire  [5:0] cnt_nxt  = idle ? 6'h00 : ((bit_tick & ~done_r) ? cnt_inc : cnt_r);
    wire        done_nxt = idle ? 1'b0 : (done_r | hit);

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r  <= 6'h00;
            done_r <= 1'b0;
            fire_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            done_r <= done_nxt;
            fire_r <= hit;
        end
    end

    assign fire = fire_r;

endmodule // uifl_rx_timeout

//--- hdl/uifl_core.sv
`timescale 1ns/1ps
// Notes on behaviour
// - line status interrupt on new error bits 1-4; cleared by line status read
// - receive timeout after four characters plus twelve bits; cleared by data read
// - receive ready interrupt while fifo level at or above trigger; any data with fifos disabled
// - transmit ready on falling below trigger or empty; cleared by status read or data write
// - modem interrupt on any delta bit 0-3; cleared by modem register read
// - xoff interrupt on xoff match; cleared by status read or xon receipt
// - special character interrupt; cleared by status read or next received character
// - cts/rts deassert interrupts under auto flow; cleared by modem register read
// - wake-up interrupt on sleep exit, code 000001, cleared by status read
// - codes: line status 000110, timeout 001100, receive ready 000100
// - codes: tx 000010, modem 000000, xoff 010000, flow 100000, none 000001
// - status bit 0 low while pending, high when idle or wake-up only
// - status bit 4 reports character match only with enhanced bit 4 set
// - status bit 5 reports cts/rts deassert only with enhanced bit 4 set
// - status bits 7:6 read 11 with fifos enabled, 00 otherwise
// - fifo enable defaults 0; other setup bits written only with bit 0 set
// - fifo reset bits pulse pointer reset once, then read back as zero
// - transmit trigger 1/4/8/14, writable only with enhanced bit 4 set
// - receive trigger 1/4/8/14 for codes 00..11
// - word length 5 to 8 from format bits 1:0
// - stop bit select: one, or 1.5 for 5-bit words, else two
// - parity enable, odd/even, forced mark/space
// - each classic source gated by its mask bit; timeout shares the receive mask bit
// - status read shows only the top pending source; others stay queued
module uifl_core (
    // clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   resetn,
    // register port
    input  wire logic [uifl_pkg::AW-1:0] addr,
    input  wire logic [7:0]             wdata,
    input  wire logic                   wr_stb,
    input  wire logic                   rd_stb,
    output logic      [7:0]             rdata,
    // receive side status
    input  wire logic [4:0]             rx_level,
    input  wire logic                   rx_char,
    input  wire logic                   bit_tick,
    input  wire logic [3:0]             lsr_err,
    // transmit side status
    input  wire logic [4:0]             tx_level,
    // modem and flow events
    input  wire logic [3:0]             msr_delta,
    input  wire logic                   xoff_det,
    input  wire logic                   xon_det,
    input  wire logic                   special_det,
    input  wire logic                   cts_deassert,
    input  wire logic                   rts_deassert,
    input  wire logic                   wake_evt,
    // interrupt and fifo control
    output logic                        irq_active,
    output logic                        fifo_en,
    output logic                        rx_fifo_rst,
    output logic                        tx_fifo_rst,
    output logic      [4:0]             rx_trig,
    output logic      [4:0]             tx_trig,
    // character format
    output logic      [3:0]             word_len,
    output logic                        stop_two,
    output logic                        stop_half,
    output logic                        parity_en,
    output logic                        parity_even,
    output logic                        parity_forced,
    output logic                        parity_force_val,
    output logic                        break_en,
    output logic                        divisor_sel,
    // enhanced features
    output logic                        enh_en,
    output logic                        auto_rts_en,
    output logic                        auto_cts_en,
    output logic                        sleep_en
);
    import uifl_pkg::*;

    logic [7:0]       ier_r;
    logic [7:0]       lcr_r;
    logic [7:0]       efr_r;
    logic             fifo_en_r;
    logic [1:0]       rxt_r;
    logic [1:0]       txt_r;
    logic             rxrst_r;
    logic             txrst_r;
    logic [NFLAG-1:0] flag_r;
    logic [NFLAG-1:0] flag_nxt;
    logic             err_q;
    logic             delta_q;
    logic [4:0]       tx_level_q;
    logic [7:0]       rdata_r;
    logic             to_fire;
    logic [5:0]       to_limit;
    uifl_src_e        src;
    logic [5:0]       isr_code;

    // address decode; the divisor latch bit hides the data and mask slots
    wire dlab   = lcr_r[LCR_DLAB];
    wire enh    = efr_r[EFR_ENH];
    wire wr_thr = wr_stb && (addr == A_DATA) && !dlab;
    wire rd_rhr = rd_stb && (addr == A_DATA) && !dlab;
    wire wr_ier = wr_stb && (addr == A_IER) && !dlab;
    wire rd_isr = rd_stb && (addr == A_ISR);
    wire wr_fcr = wr_stb && (addr == A_ISR);
    wire wr_lcr = wr_stb && (addr == A_LCR);
    wire wr_efr = wr_stb && (addr == A_EFR);
    wire rd_lsr = rd_stb && (addr == A_LSR);
    wire rd_msr = rd_stb && (addr == A_MSR);

    // fifo setup
    wire       fcr_upd    = wr_fcr & wdata[FCR_EN];
    wire       fifo_en_nx = wr_fcr ? wdata[FCR_EN] : fifo_en_r;
    wire [1:0] rxt_nxt    = fcr_upd ? wdata[FCR_RXT+1:FCR_RXT] : rxt_r;
    wire [1:0] txt_nxt    = (fcr_upd & enh) ? wdata[FCR_TXT+1:FCR_TXT] : txt_r;
    wire       rxrst_nxt  = fcr_upd & wdata[FCR_RXRST];
    wire       txrst_nxt  = fcr_upd & wdata[FCR_TXRST];

    // upper mask bits need the enhanced gate
    wire [7:0] ier_nxt = wr_ier ? {(enh ? wdata[7:4] : ier_r[7:4]), wdata[3:0]} : ier_r;
    wire [7:0] lcr_nxt = wr_lcr ? wdata : lcr_r;
    wire [7:0] efr_nxt = wr_efr ? wdata : efr_r;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ier_r     <= IER_RST;
            lcr_r     <= LCR_RST;
            efr_r     <= EFR_RST;
            fifo_en_r <= 1'b0;
            rxt_r     <= TRG_RST;
            txt_r     <= TRG_RST;
            rxrst_r   <= 1'b0;
            txrst_r   <= 1'b0;
        end else begin
            ier_r     <= ier_nxt;
            lcr_r     <= lcr_nxt;
            efr_r     <= efr_nxt;
            fifo_en_r <= fifo_en_nx;
            rxt_r     <= rxt_nxt;
            txt_r     <= txt_nxt;
            rxrst_r   <= rxrst_nxt;
            txrst_r   <= txrst_nxt;
        end
    end

    uifl_trig_sel u_rx_trig (
        .code  (rxt_r),
        .level (rx_trig)
    );

    uifl_trig_sel u_tx_trig (
        .code  (txt_r),
        .level (tx_trig)
    );

    // character format decode
    assign word_len         = WL_BASE + {2'b00, lcr_r[LCR_WL+1:LCR_WL]};
    assign stop_half        = lcr_r[LCR_STB] & (lcr_r[LCR_WL+1:LCR_WL] == 2'h0);
    assign stop_two         = lcr_r[LCR_STB] & ~stop_half;
    assign parity_en        = lcr_r[LCR_PEN];
    assign parity_forced    = lcr_r[LCR_PEN] & lcr_r[LCR_STK];
    assign parity_even      = lcr_r[LCR_PEN] & ~lcr_r[LCR_STK] & lcr_r[LCR_EPS];
    assign parity_force_val = ~lcr_r[LCR_EPS];
    assign break_en         = lcr_r[LCR_BRK];
    assign divisor_sel      = dlab;

    // timeout span; a 1.5 stop bit rounds up to two so the span never runs short
    wire [3:0] stop_bits = lcr_r[LCR_STB] ? STOP_LONG : STOP_ONE;
    wire [3:0] char_bits = START_BITS + word_len + {3'b000, lcr_r[LCR_PEN]} + stop_bits;
    assign to_limit = 6'({2'b00, char_bits} * TO_CHARS) + TO_EXTRA_BITS;

    uifl_rx_timeout u_rx_to (
        .sys_clk  (sys_clk),
        .resetn   (resetn),
        .bit_tick (bit_tick),
        .restart  (rx_char | rd_rhr),
        .armed    (fifo_en_r & (rx_level != 5'h00)),
        .limit    (to_limit),
        .fire     (to_fire)
    );

    // source events
    wire err_any    = |lsr_err;
    wire delta_any  = |msr_delta;
    wire err_rise   = err_any & ~err_q;
    wire delta_rise = delta_any & ~delta_q;
    wire tx_empty   = (tx_level == 5'h00);
    wire tx_empty_q = (tx_level_q == 5'h00);
    wire tx_drop    = fifo_en_r & (tx_level < tx_trig) & (tx_level_q >= tx_trig);
    wire tx_arm     = wr_ier & wdata[IER_TX] & ~ier_r[IER_TX] & tx_empty;
    wire tx_set     = (tx_empty & ~tx_empty_q) | tx_drop | tx_arm;
    wire rx_ready   = fifo_en_r ? (rx_level >= rx_trig) : (rx_level != 5'h00);

    // gated pending sources, highest first
    wire p_ls = flag_r[F_LS] & ier_r[IER_RLS];
    wire p_to = flag_r[F_TO] & ier_r[IER_RX];
    wire p_rx = rx_ready & ier_r[IER_RX];
    wire p_tx = flag_r[F_TX] & ier_r[IER_TX];
    wire p_ms = flag_r[F_MS] & ier_r[IER_MS];
    wire p_xs = enh & ier_r[IER_XOFF] & (flag_r[F_XOFF] | flag_r[F_SPEC]);
    wire p_fl = enh & ((flag_r[F_CTS] & ier_r[IER_CTS]) |
                       (flag_r[F_RTS] & ier_r[IER_RTS]));

    assign src = p_ls ? SRC_LS :
                 p_to ? SRC_RXTO :
                 p_rx ? SRC_RECEIVE_DATA_READY_IRQ :
                 p_tx ? SRC_TRANSMIT_READY_IRQ :
                 p_ms ? SRC_MS :
                 p_xs ? SRC_XS :
                 p_fl ? SRC_FLOW :
                 flag_r[F_WAKE] ? SRC_WAKE : SRC_NONE;

    always_comb begin
        unique case (src)
            SRC_LS:    isr_code = C_LS;
            SRC_RXTO:  isr_code = C_RXTO;
            SRC_RECEIVE_DATA_READY_IRQ: isr_code = C_RECEIVE_DATA_READY_IRQ;
            SRC_TRANSMIT_READY_IRQ: isr_code = C_TRANSMIT_READY_IRQ;
            SRC_MS:    isr_code = C_MS;
            SRC_XS:    isr_code = C_XS;
            SRC_FLOW:  isr_code = C_FLOW;
            SRC_WAKE:  isr_code = C_NONE;
            SRC_NONE:  isr_code = C_NONE;
            default:   isr_code = C_NONE;
        endcase
    end

    wire [7:0] isr_byte = {{2{fifo_en_r}}, isr_code};

    // a status read only acknowledges the source it actually returned
    wire ack_tx   = rd_isr && (src == SRC_TRANSMIT_READY_IRQ);
    wire ack_xs   = rd_isr && (src == SRC_XS);
    wire ack_wake = rd_isr && (src == SRC_WAKE);

    // set wins over clear; clears act on the edge that ends the read
    always_comb begin
        flag_nxt         = flag_r;
        flag_nxt[F_LS]   = err_rise | (flag_r[F_LS] & ~rd_lsr);
        flag_nxt[F_TO]   = to_fire | (flag_r[F_TO] & ~rd_rhr);
        flag_nxt[F_TX]   = tx_set | (flag_r[F_TX] & ~(wr_thr | ack_tx));
        flag_nxt[F_MS]   = delta_rise | (flag_r[F_MS] & ~rd_msr);
        flag_nxt[F_XOFF] = xoff_det | (flag_r[F_XOFF] & ~(ack_xs | xon_det));
        flag_nxt[F_SPEC] = special_det | (flag_r[F_SPEC] & ~(ack_xs | rx_char));
        flag_nxt[F_CTS]  = (cts_deassert & efr_r[EFR_ACTS]) |
                           (flag_r[F_CTS] & ~rd_msr);
        flag_nxt[F_RTS]  = (rts_deassert & efr_r[EFR_ARTS]) |
                           (flag_r[F_RTS] & ~rd_msr);
        flag_nxt[F_WAKE] = wake_evt | (flag_r[F_WAKE] & ~ack_wake);
    end

    // read mux; unmapped and foreign slots read as zero
    wire [7:0] rd_mux = ((addr == A_IER) && !dlab) ? ier_r :
                        (addr == A_ISR) ? isr_byte :
                        (addr == A_LCR) ? lcr_r :
                        (addr == A_EFR) ? efr_r : RD_ZERO;
    wire [7:0] rdata_nxt = rd_stb ? rd_mux : RD_ZERO;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            flag_r     <= '0;
            err_q      <= 1'b0;
            delta_q    <= 1'b0;
            tx_level_q <= 5'h00;
            rdata_r    <= RD_ZERO;
        end else begin
            flag_r     <= flag_nxt;
            err_q      <= err_any;
            delta_q    <= delta_any;
            tx_level_q <= tx_level;
            rdata_r    <= rdata_nxt;
        end
    end

    assign rdata       = rdata_r;
    assign irq_active  = ~isr_code[0];
    assign fifo_en     = fifo_en_r;
    assign rx_fifo_rst = rxrst_r;
    assign tx_fifo_rst = txrst_r;
    assign enh_en      = enh;
    assign auto_rts_en = efr_r[EFR_ARTS];
    assign auto_cts_en = efr_r[EFR_ACTS];
    assign sleep_en    = ier_r[IER_SLEEP];

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence s_isr_read_ls;
        rd_isr && p_ls;
    endsequence

    a_ls_read_clear: assert property (rd_lsr && !err_rise |=> !flag_r[F_LS])
        else $error("line status flag survived its read");
    a_to_fire_set: assert property (to_fire |=> flag_r[F_TO])
        else $error("timeout fire not latched");
    a_rx_level_code: assert property (ier_r[IER_RX] && fifo_en_r && rx_level >= rx_trig
        && !p_ls && !p_to |-> isr_code == 6'h04)
        else $error("receive ready code wrong");
    a_tx_write_clear: assert property (wr_thr && !tx_set |=> !flag_r[F_TX])
        else $error("transmit ready not cleared by data write");
    a_ls_top_code: assert property (p_ls |-> isr_code == 6'h06 && irq_active)
        else $error("line status not reported first");
    a_idle_code: assert property (!(p_ls | p_to | p_rx | p_tx | p_ms | p_xs | p_fl)
        |-> isr_code == 6'h01 && !irq_active)
        else $error("idle status code wrong");
    a_fifo_rst_pulse: assert property (wr_fcr && wdata[0] && wdata[1]
        |=> rx_fifo_rst ##1 !rx_fifo_rst)
        else $error("receive fifo reset not one pulse");
    a_fcr_gate_hold: assert property (wr_fcr && !wdata[0]
        |=> $stable(rx_trig) && $stable(tx_trig) && !fifo_en)
        else $error("setup bits changed without enable");
    a_isr_fifo_bits: assert property (rd_isr |=> rdata[7:6] == {2{$past(fifo_en_r)}})
        else $error("fifo status bits wrong");
    a_read_shows_old: assert property (s_isr_read_ls |=> rdata[5:0] == 6'h06)
        else $error("read did not show the pending source");
    a_spec_auto_clear: assert property (flag_r[F_SPEC] && rx_char && !special_det
        |=> !flag_r[F_SPEC])
        else $error("special character flag not cleared by next character");

endmodule // uifl_core

//--- testbench/uifl_far_model.sv
`timescale 1ns/1ps
module uifl_far_model #(
    parameter int DIV = 4
) (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic resetn,
    // arrival request
    input  wire logic send,
    // towards the core
    output logic      bit_tick,
    output logic      rx_char
);
    logic [7:0] div_r;
    // baud tick runs free, so the timeout keeps counting between characters
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            div_r    <= 8'h00;
            bit_tick <= 1'b0;
            rx_char  <= 1'b0;
        end else begin
            div_r    <= (div_r == 8'(DIV - 1)) ? 8'h00 : div_r + 8'h01;
            bit_tick <= (div_r == 8'(DIV - 1));
            rx_char  <= send;
        end
    end
endmodule // uifl_far_model

//--- testbench/tb.sv
`timescale 1ns/1ps
module tb;
    import uifl_pkg::*;
    logic       sys_clk = 0, resetn = 0, wr_stb = 0, rd_stb = 0, snd = 0;
    logic [2:0] addr = 0;
    logic [7:0] wdata = 0, rdata, d;
    logic [4:0] rx_level = 0, tx_level = 0, rx_trig, tx_trig;
    logic [3:0] lsr_err = 0, msr_delta = 0, word_len;
    logic [5:0] ev = 0;
    logic       bit_tick, rx_char, irq_active, fifo_en, rx_fifo_rst, tx_fifo_rst;
    logic       stop_two, stop_half, parity_en, parity_even, parity_forced, parity_force_val;
    logic       break_en, divisor_sel, enh_en, auto_rts_en, auto_cts_en, sleep_en;
    logic [4:0] lv [4] = '{5'h01, 5'h04, 5'h08, 5'h0e};
    int         bad_count = 0, compares = 0;

    uifl_far_model uifl_far_model_i (.sys_clk, .resetn, .send(snd), .bit_tick, .rx_char);
    uifl_core uifl_core_i (.sys_clk, .resetn, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
        .rx_level, .rx_char, .bit_tick, .lsr_err, .tx_level, .msr_delta, .xoff_det(ev[0]),
        .xon_det(ev[1]), .special_det(ev[2]), .cts_deassert(ev[3]), .rts_deassert(ev[4]),
        .wake_evt(ev[5]), .irq_active, .fifo_en, .rx_fifo_rst, .tx_fifo_rst, .rx_trig,
        .tx_trig, .word_len, .stop_two, .stop_half, .parity_en, .parity_even, .parity_forced,
        .parity_force_val, .break_en, .divisor_sel, .enh_en, .auto_rts_en,
        .auto_cts_en, .sleep_en);

    initial forever #12.5 sys_clk = ~sys_clk;

    task print_verdict;
        if (bad_count == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge sys_clk) begin addr <= a; wdata <= v; wr_stb <= 1; end
        @(posedge sys_clk) wr_stb <= 0;
        #1;
    endtask
    task rd(input logic [2:0] a);
        @(posedge sys_clk) begin addr <= a; rd_stb <= 1; end
        @(posedge sys_clk) rd_stb <= 0;
        #1 d = rdata;
    endtask
    task interrupt_source_status(input logic [7:0] e);
        rd(A_ISR);
        chk(d, e);
    endtask
    task pulse(input int i);
        @(posedge sys_clk) ev[i] <= 1;
        @(posedge sys_clk) ev[i] <= 0;
    endtask
    task arrive;
        @(posedge sys_clk) snd <= 1;
        @(posedge sys_clk) snd <= 0;
        repeat (2) @(posedge sys_clk);
    endtask

    task t_reset;
        interrupt_source_status(8'h01);
        rd(A_LCR);
        chk(d, LCR_RST);
        chk({word_len, 1'b0, fifo_en, irq_active, stop_two}, 8'h50);
        chk({rx_trig, tx_trig[2:0]}, 8'h09);
    endtask
    task t_format;
        for (int i = 0; i < 4; i++) begin
            wr(A_LCR, 8'h1c | 8'(i));
            chk({word_len, stop_two, stop_half, parity_en, parity_even},
                {4'(5 + i), i != 0, i == 0, 2'b11});
            rd(A_LCR);
            chk(d, 8'h1c | 8'(i));
        end
        wr(A_LCR, 8'h28);
        chk({parity_en, parity_forced, parity_force_val}, 8'h07);
        wr(A_LCR, 8'h38);
        chk({parity_forced, parity_force_val}, 8'h02);
        wr(A_LCR, 8'hc0);
        chk({break_en, divisor_sel}, 8'h03);
        wr(A_LCR, LCR_RST);
        chk({break_en, divisor_sel}, 8'h00);
    endtask
    task t_fifo;
        wr(A_ISR, 8'hc0);
        chk({fifo_en, rx_trig}, 8'h01);
        interrupt_source_status(8'h01);
        for (int i = 0; i < 4; i++) begin
            wr(A_ISR, {2'(i), 6'h01});
            chk({fifo_en, rx_trig}, {3'h1, lv[i]});
        end
        interrupt_source_status(8'hc1);
        wr(A_ISR, 8'h31);
        chk(tx_trig, 8'h01);
        wr(A_ISR, 8'h07);
        chk({rx_fifo_rst, tx_fifo_rst}, 8'h03);
        @(posedge sys_clk) #1;
        chk({rx_fifo_rst, tx_fifo_rst}, 8'h00);
    endtask
    task t_prio;
        @(posedge sys_clk) msr_delta <= 4'h1;
        interrupt_source_status(8'hc1);
        rd(A_MSR);
        @(posedge sys_clk) msr_delta <= 0;
        wr(A_IER, 8'h0f);
        @(posedge sys_clk) begin lsr_err <= 4'h2; msr_delta <= 4'h8; rx_level <= 1; end
        interrupt_source_status(8'hc6);
        chk(irq_active, 8'h01);
        rd(A_LSR);
        interrupt_source_status(8'hc4);
        @(posedge sys_clk) rx_level <= 0;
        interrupt_source_status(8'hc2);
        interrupt_source_status(8'hc0);
        rd(A_MSR);
        interrupt_source_status(8'hc1);
        chk(irq_active, 8'h00);
        @(posedge sys_clk) tx_level <= 1;
        @(posedge sys_clk) tx_level <= 0;
        interrupt_source_status(8'hc2);
        // raise it again so the data write, not the status read, does the clearing
        @(posedge sys_clk) tx_level <= 1;
        @(posedge sys_clk) tx_level <= 0;
        repeat (2) @(posedge sys_clk);
        #1 chk(irq_active, 8'h01);
        wr(A_DATA, 8'h55);
        interrupt_source_status(8'hc1);
        @(posedge sys_clk) begin lsr_err <= 0; msr_delta <= 0; end
    endtask
    task t_timeout;
        wr(A_ISR, 8'h41);
        wr(A_IER, 8'h01);
        @(posedge sys_clk) rx_level <= 1;
        arrive();
        repeat (136) @(posedge sys_clk);
        interrupt_source_status(8'hc1);
        repeat (80) @(posedge sys_clk);
        interrupt_source_status(8'hcc);
        rd(A_DATA);
        interrupt_source_status(8'hc1);
        @(posedge sys_clk) rx_level <= 0;
    endtask
    task t_flow;
        pulse(0);
        interrupt_source_status(8'hc1);
        pulse(1);
        wr(A_EFR, 8'hd0);
        wr(A_IER, 8'he0);
        chk({enh_en, auto_rts_en, auto_cts_en, sleep_en}, 8'h0e);
        pulse(0);
        interrupt_source_status(8'hd0);
        interrupt_source_status(8'hc1);
        pulse(0);
        pulse(1);
        interrupt_source_status(8'hc1);
        pulse(2);
        interrupt_source_status(8'hd0);
        pulse(2);
        arrive();
        interrupt_source_status(8'hc1);
        for (int i = 3; i < 5; i++) begin
            pulse(i);
            interrupt_source_status(8'he0);
            rd(A_MSR);
            interrupt_source_status(8'hc1);
        end
        pulse(5);
        interrupt_source_status(8'hc1);
        chk(irq_active, 8'h00);
        wr(A_ISR, 8'h31);
        chk(tx_trig, 8'h0e);
    endtask

    initial begin
        repeat (10) @(posedge sys_clk);
        resetn <= 1;
        t_reset();
        t_format();
        t_fifo();
        t_prio();
        t_timeout();
        t_flow();
        print_verdict();
    end
    initial begin
        repeat (5000) @(posedge sys_clk);
        bad_count++;
        print_verdict();
    end
endmodule // tb
